// File: rtl/adc_fabric_result_port.sv
`timescale 1ns/100ps
`include "adc_fabric_result_port_defines.svh"

module adc_fabric_result_port #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              fabric_mode_i,
  input  wire logic              sample_done_i,
  input  wire logic [`TAG_W-1:0] sample_chan_i,
  input  wire logic [`CFG_W-1:0] sample_cfg_i,
  input  wire logic              conv_done_i,
  input  wire logic [`CFG_W-1:0] conv_cfg_i,
  input  wire logic [`RES_W-1:0] conv_result_i,
  input  wire logic              conv_sat_i,
  input  wire logic              conv_rng_i,
  input  wire logic              conv_last_i,
  output logic                   conv_ready_o,
  input  wire logic              hilo_sel_i,
  output logic [`RES_W-1:0]      result_reg_o,
  output logic                   fabric_sample_done_o,
  output logic [`TAG_W-1:0]      fabric_channel_tag_o,
  output logic                   fabric_channel_tag_valid_o,
  output logic [`OUT_W-1:0]      fabric_data_o,
  output logic                   fabric_data_valid_o,
  output logic                   fabric_eos_o
);

  localparam int WORD_W = $bits(adc_fabric_result_pkg::conv_word_t);

  adc_fabric_result_pkg::port_state_t st_r;
  adc_fabric_result_pkg::port_state_t st_nxt;
  adc_fabric_result_pkg::conv_word_t  in_word;
  adc_fabric_result_pkg::conv_word_t  fifo_word;
  logic [WORD_W-1:0]                  fifo_bits;
  logic                               fifo_valid;
  logic                               fifo_ready;
  logic                               in_take;
  logic                               stage_free;
  logic                               take_fifo;
  logic                               take_direct;
  logic                               push;
  logic                               tag_take;

  // True when a configuration word enables the fabric output of its channel.
  function automatic logic out_enabled(input logic [`CFG_W-1:0] cfg);
    return cfg[`CFG_OUT_EN_BIT];
  endfunction

  // Incoming word. In fabric-control mode every single conversion ends a scan.
  always_comb
  begin
    in_word.res = conv_result_i;
    in_word.sat = conv_sat_i;
    in_word.rng = conv_rng_i;
    in_word.eos = conv_last_i || fabric_mode_i;
  end

  // Stage arbitration. The FIFO is bypassed when it is empty and the stage is
  // free, which keeps the one-cycle latency; it only absorbs conversions that
  // arrive while an earlier result is still being held.
  assign in_take     = conv_done_i && out_enabled(conv_cfg_i);
  assign stage_free  = (st_r.dstate == adc_fabric_result_pkg::D_IDLE) ||
                       (st_r.dstate == adc_fabric_result_pkg::D_HOLD2);
  assign take_fifo   = stage_free && fifo_valid;
  assign take_direct = stage_free && !fifo_valid && in_take;
  assign push        = in_take && !take_direct;
  assign fifo_word   = adc_fabric_result_pkg::conv_word_t'(fifo_bits);
  assign tag_take    = sample_done_i && out_enabled(sample_cfg_i) && !fabric_mode_i;

  // Back-pressure to the sequencer: a conversion offered while the FIFO is full
  // cannot be kept, so the sequencer must wait for this ready.
  assign conv_ready_o = fifo_ready;

  result_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (in_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (take_fifo),
    .out_data_o  (fifo_bits)
  );

  // Next state of the whole port.
  always_comb
  begin
    st_nxt = st_r;
    // Sampling-finished pulse, one cycle late so that it leaves a flip-flop.
    st_nxt.sdone = sample_done_i;
    // Every conversion lands in the result register, enabled or not.
    if (conv_done_i)
    begin
      st_nxt.result = conv_result_i;
    end
    // Early channel tag, held for the fixed count of cycles.
    if (st_r.tcnt != 2'd0)
    begin
      st_nxt.tcnt = st_r.tcnt - 2'd1;
    end
    if (tag_take)
    begin
      st_nxt.tag  = sample_chan_i;
      st_nxt.tcnt = `HOLD_CYCLES;
    end
    // Result stage: load, then hold for two cycles.
    case (st_r.dstate)
      adc_fabric_result_pkg::D_IDLE:
      begin
        if (take_fifo || take_direct)
        begin
          st_nxt.dstate = adc_fabric_result_pkg::D_HOLD1;
          st_nxt.word   = take_fifo ? fifo_word : in_word;
        end
      end
      adc_fabric_result_pkg::D_HOLD1:
      begin
        st_nxt.dstate = adc_fabric_result_pkg::D_HOLD2;
      end
      adc_fabric_result_pkg::D_HOLD2:
      begin
        if (take_fifo || take_direct)
        begin
          st_nxt.dstate = adc_fabric_result_pkg::D_HOLD1;
          st_nxt.word   = take_fifo ? fifo_word : in_word;
        end
        else
        begin
          st_nxt.dstate = adc_fabric_result_pkg::D_IDLE;
        end
      end
      default:
      begin
        st_nxt.dstate = adc_fabric_result_pkg::D_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r.dstate <= adc_fabric_result_pkg::D_IDLE;
      st_r.word   <= '0;
      st_r.tcnt   <= 2'd0;
      st_r.tag    <= `RST_TAG;
      st_r.sdone  <= 1'b0;
      st_r.result <= `RST_RESULT;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Simple outputs straight from the state.
  assign result_reg_o         = st_r.result;
  assign fabric_sample_done_o = st_r.sdone;
  assign fabric_data_valid_o  = (st_r.dstate != adc_fabric_result_pkg::D_IDLE);
  assign fabric_eos_o         = fabric_data_valid_o && st_r.word.eos;

  // The half select is a pure mux so the fabric can flip it within one cycle
  // of the hold window and read both parts; the unused high lines read zero.
  assign fabric_data_o = hilo_sel_i ?
    {{`PAD_W{1'b0}}, st_r.word.res[`HI_MSB:`HI_LSB]} :
    st_r.word.res[`LO_MSB:0];

  // In fabric-control mode the tag carries the flags and rides with the result.
  // The mode input is taken live, so it must not change while a result is held.
  always_comb
  begin
    if (fabric_mode_i)
    begin
      fabric_channel_tag_o                 = '0;
      fabric_channel_tag_o[`TAG_SAT_BIT]   = st_r.word.sat;
      fabric_channel_tag_o[`TAG_RNG_BIT]   = st_r.word.rng;
      fabric_channel_tag_valid_o           = fabric_data_valid_o;
    end
    else
    begin
      fabric_channel_tag_o       = st_r.tag;
      fabric_channel_tag_valid_o = (st_r.tcnt != 2'd0);
    end
  end

  // A strobe that rises stays for two cycles with a stable value.
  sequence held_two_data;
    fabric_data_valid_o ##1 fabric_data_valid_o && $stable(st_r.word);
  endsequence

  sequence held_two_tag;
    fabric_channel_tag_valid_o ##1 fabric_channel_tag_valid_o && $stable(st_r.tag);
  endsequence

  chk_result_store: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_done_i |=> result_reg_o == $past(conv_result_i))
    else $error("Result register missed a conversion.");

  chk_data_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
    take_direct |=> fabric_data_valid_o && st_r.word.res == $past(conv_result_i))
    else $error("Result not on fabric one cycle after conversion.");

  chk_data_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(fabric_data_valid_o) |-> held_two_data)
    else $error("Result not held for two cycles.");

  chk_data_window: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(fabric_data_valid_o) |->
      (##1 (take_fifo || take_direct)) or (##2 !fabric_data_valid_o))
    else $error("Result strobe longer than its hold window.");

  chk_hilo_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    !hilo_sel_i |-> fabric_data_o == st_r.word.res[`LO_MSB:0])
    else $error("Low half select gives wrong bits.");

  chk_hilo_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    hilo_sel_i |-> fabric_data_o[`HI_OUT_MSB:0] == st_r.word.res[`HI_MSB:`HI_LSB])
    else $error("High half select gives wrong bits.");

  chk_tag_early: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_take && !fabric_mode_i |=> fabric_mode_i ||
      (fabric_channel_tag_valid_o && fabric_channel_tag_o == $past(sample_chan_i)))
    else $error("Channel tag not presented after sampling.");

  chk_tag_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    tag_take |=> held_two_tag ##1 (!(st_r.tcnt != 2'd0) || $past(tag_take)))
    else $error("Channel tag strobe not exactly two cycles.");

  chk_sdone_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    sample_done_i |=> fabric_sample_done_o)
    else $error("Sampling-finished pulse missing.");

  chk_fabric_tag: assert property (@(posedge mclk_i) disable iff (rst_i)
    fabric_mode_i && fabric_data_valid_o |->
      fabric_channel_tag_o[`TAG_SAT_BIT] == st_r.word.sat &&
      fabric_channel_tag_o[`TAG_RNG_BIT] == st_r.word.rng)
    else $error("Fabric-mode tag flags wrong.");

  chk_eos_copy: assert property (@(posedge mclk_i) disable iff (rst_i)
    fabric_mode_i && take_direct |=> fabric_eos_o == fabric_data_valid_o)
    else $error("End-of-scan is not a copy of result valid.");

  chk_eos_scan: assert property (@(posedge mclk_i) disable iff (rst_i)
    take_direct && conv_last_i |=> fabric_eos_o [*2])
    else $error("End-of-scan pulse missing after last channel.");

endmodule

// File: rtl/adc_fabric_result_port_defines.svh
`ifndef ADC_FABRIC_RESULT_PORT_DEFINES_SVH
`define ADC_FABRIC_RESULT_PORT_DEFINES_SVH

// Widths of the stored result, the fabric result lines, the channel tag and the configuration word.
`define RES_W          16
`define OUT_W          12
`define TAG_W          4
`define CFG_W          32

// Channel configuration bit that enables the fabric output.
`define CFG_OUT_EN_BIT 31

// Field positions of the result halves on the fabric lines.
`define LO_MSB         11
`define HI_MSB         15
`define HI_LSB         8
`define HI_OUT_MSB     7
`define PAD_W          4

// Positions of the saturation and range flags in the tag in fabric-control mode.
`define TAG_SAT_BIT    0
`define TAG_RNG_BIT    1

// Hold time of the early channel tag, in system clock cycles, and the FIFO depth in entries.
`define HOLD_CYCLES    2'd2
`define FIFO_DEPTH     8

// Reset values.
`define RST_RESULT     16'h0000
`define RST_TAG        4'h0

`endif

// File: rtl/adc_fabric_result_pkg.sv
`include "adc_fabric_result_port_defines.svh"

package adc_fabric_result_pkg;

  // One finished conversion on its way to the fabric.
  typedef struct packed {
    logic [`RES_W-1:0] res;
    logic              sat;
    logic              rng;
    logic              eos;
  } conv_word_t;

  // Output stage: idle, first held cycle, second held cycle.
  typedef enum logic [2:0] {
    D_IDLE  = 3'b001,
    D_HOLD1 = 3'b010,
    D_HOLD2 = 3'b100
  } data_state_t;

  // All state of the port except the FIFO.
  typedef struct packed {
    data_state_t       dstate;
    conv_word_t        word;
    logic [1:0]        tcnt;
    logic [`TAG_W-1:0] tag;
    logic              sdone;
    logic [`RES_W-1:0] result;
  } port_state_t;

endpackage

// File: rtl/result_fifo.sv
`timescale 1ns/100ps

module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic        do_push;
  logic        do_pop;

  // Full and empty come straight from the count, so both sides see honest flags.
  assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  // The head is read without a register so the drain side loses no cycle.
  assign out_data_o  = st_r.mem[st_r.rptr];
  assign do_push     = in_valid_i && in_ready_o;
  assign do_pop      = out_ready_i && out_valid_o;

  // Pointer and count update; pointers wrap at the depth.
  always_comb
  begin
    st_nxt = st_r;
    if (do_push)
    begin
      st_nxt.mem[st_r.wptr] = in_data_i;
      st_nxt.wptr = (st_r.wptr == AW'(DEPTH-1)) ? '0 : st_r.wptr + 1'b1;
    end
    if (do_pop)
    begin
      st_nxt.rptr = (st_r.rptr == AW'(DEPTH-1)) ? '0 : st_r.rptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: sim/fabric_merge_model.sv
`timescale 1ns/100ps

module fabric_merge_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        data_valid_i,
  input  wire logic [11:0] data_i,
  output logic             hilo_sel_o,
  output logic [15:0]      word_o,
  output logic             word_valid_o,
  output logic             overlap_ok_o
);
  logic [11:0] lo_r;

  // Low half in the first held cycle, high half in the second, then merged.
  // The select flips right after an edge, so the lines must follow it without a clock.
  // Sixteen bits are rebuilt, the only case where left alignment would pay off.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hilo_sel_o   <= 1'b0;
      lo_r         <= 12'h000;
      word_o       <= 16'h0000;
      word_valid_o <= 1'b0;
      overlap_ok_o <= 1'b0;
    end
    else
    begin
      word_valid_o <= data_valid_i & hilo_sel_o;
      hilo_sel_o   <= data_valid_i & ~hilo_sel_o;
      if (!hilo_sel_o)
        lo_r <= data_i;
      else
      begin
        word_o       <= {data_i[7:0], lo_r[7:0]};
        overlap_ok_o <= (data_i[3:0] == lo_r[11:8]);
      end
    end
  end
endmodule

// File: sim/adc_fabric_result_port_tb_top.sv
`timescale 1ns/100ps
`include "adc_fabric_result_port_defines.svh"

module adc_fabric_result_port_tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        fabric_mode_i = 1'b0;
  logic        sample_done_i = 1'b0;
  logic [3:0]  sample_chan_i = 4'h0;
  logic [31:0] sample_cfg_i = 32'h0;
  logic        conv_done_i = 1'b0;
  logic [31:0] conv_cfg_i = 32'h0;
  logic [15:0] conv_result_i = 16'h0;
  logic        conv_sat_i = 1'b0;
  logic        conv_rng_i = 1'b0;
  logic        conv_last_i = 1'b0;
  logic        hilo_sel, conv_ready, sdone, tag_valid, dv, eos, wv, ovl;
  logic [15:0] result_reg, word;
  logic [3:0]  tag;
  logic [11:0] data;
  logic [15:0] exp_q[$];
  int          num_errors = 0;
  int          tests_run = 0;

  // The clock flips every half period of 2.5 ns.
  always #2.5 mclk_i = ~mclk_i;

  adc_fabric_result_port u_adc_fabric_result_port (
    .mclk_i(mclk_i), .rst_i(rst_i), .fabric_mode_i(fabric_mode_i),
    .sample_done_i(sample_done_i), .sample_chan_i(sample_chan_i), .sample_cfg_i(sample_cfg_i),
    .conv_done_i(conv_done_i), .conv_cfg_i(conv_cfg_i), .conv_result_i(conv_result_i),
    .conv_sat_i(conv_sat_i), .conv_rng_i(conv_rng_i), .conv_last_i(conv_last_i),
    .conv_ready_o(conv_ready), .hilo_sel_i(hilo_sel), .result_reg_o(result_reg),
    .fabric_sample_done_o(sdone), .fabric_channel_tag_o(tag),
    .fabric_channel_tag_valid_o(tag_valid), .fabric_data_o(data),
    .fabric_data_valid_o(dv), .fabric_eos_o(eos));

  fabric_merge_model u_fabric_merge_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .data_valid_i(dv), .data_i(data),
    .hilo_sel_o(hilo_sel), .word_o(word), .word_valid_o(wv), .overlap_ok_o(ovl));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc();
    @(posedge mclk_i);
    #1;
  endtask

  // One conversion pulse; returns inside the first cycle after it is taken.
  task automatic conv_once(input logic [15:0] res, input logic en, sat, rng, last);
    @(posedge mclk_i);
    conv_done_i   <= 1'b1;
    conv_result_i <= res;
    conv_cfg_i    <= {en, 31'h0};
    conv_sat_i    <= sat;
    conv_rng_i    <= rng;
    conv_last_i   <= last;
    if (en)
      exp_q.push_back(res);
    @(posedge mclk_i);
    conv_done_i <= 1'b0;
    #1;
  endtask

  // Every merged word from the fabric side must match the next expected result.
  always @(posedge mclk_i)
  begin
    if (wv && exp_q.size() == 0)
      check1("unexpected_word", 1'b0, 1'b1);
    else if (wv)
    begin
      check("merged_word", exp_q.pop_front(), word);
      check1("overlap_match", 1'b1, ovl);
    end
  end

  task automatic t_single();
    conv_once(16'ha5c3, 1'b1, 1'b0, 1'b0, 1'b1);
    check("result_reg", 16'ha5c3, result_reg);
    check1("dv_c1", 1'b1, dv);
    check("data_lo", 16'h05c3, {4'h0, data});
    check1("eos_c1", 1'b1, eos);
    cyc();
    check1("dv_c2", 1'b1, dv);
    check("data_hi", 16'h00a5, {8'h00, data[7:0]});
    cyc();
    check1("dv_c3", 1'b0, dv);
    check1("eos_c3", 1'b0, eos);
    $display("t_single done");
  endtask

  task automatic t_disabled();
    conv_once(16'h1234, 1'b0, 1'b0, 1'b0, 1'b1);
    check("reg_no_fabric", 16'h1234, result_reg);
    check1("dv_off", 1'b0, dv);
    conv_once(16'h4321, 1'b1, 1'b0, 1'b0, 1'b0);
    check1("dv_on", 1'b1, dv);
    check1("eos_not_last", 1'b0, eos);
    repeat (3) cyc();
    $display("t_disabled done");
  endtask

  task automatic t_tag();
    @(posedge mclk_i);
    sample_done_i <= 1'b1;
    sample_chan_i <= 4'h9;
    sample_cfg_i  <= 32'h8000_0000;
    @(posedge mclk_i);
    sample_done_i <= 1'b0;
    sample_cfg_i  <= 32'h0;
    #1;
    check("tag", 16'h0009, {12'h0, tag});
    check1("tv_c1", 1'b1, tag_valid);
    check1("tag_before_data", 1'b0, dv);
    check1("sdone_c1", 1'b1, sdone);
    cyc();
    check1("tv_c2", 1'b1, tag_valid);
    check1("sdone_c2", 1'b0, sdone);
    cyc();
    check1("tv_c3", 1'b0, tag_valid);
    $display("t_tag done");
  endtask

  // Mode is changed only between conversions, never inside a trigger window.
  task automatic t_fabric();
    @(posedge mclk_i);
    fabric_mode_i <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      conv_once(16'h0ab0 + 16'(k), 1'b1, k[0], k[1], 1'b0);
      check("flags", {14'h0, k[1], k[0]}, {12'h0, tag});
      check1("tv_f1", 1'b1, tag_valid);
      check1("eos_f1", 1'b1, eos);
      cyc();
      check1("eos_copy", dv, eos);
      check1("tv_f2", 1'b1, tag_valid);
      cyc();
      check1("eos_f3", 1'b0, eos);
    end
    @(posedge mclk_i);
    fabric_mode_i <= 1'b0;
    $display("t_fabric done");
  endtask

  // Offer a conversion every cycle; ready is read between edges, where it is
  // settled, and decides whether the offer at the coming edge is kept.
  task automatic t_burst();
    logic        full;
    logic [15:0] res;
    int          n;
    full = 1'b0;
    n = 0;
    while (n < 20)
    begin
      res = {n[3:0], ~n[3:0], n[3:0], 4'h5};
      @(posedge mclk_i);
      conv_done_i   <= 1'b1;
      conv_cfg_i    <= 32'h8000_0000;
      conv_result_i <= res;
      conv_last_i   <= (n == 19);
      @(negedge mclk_i);
      if (conv_ready)
      begin
        exp_q.push_back(res);
        n++;
      end
      else
      begin
        full = 1'b1;
      end
    end
    @(posedge mclk_i);
    conv_done_i <= 1'b0;
    repeat (100)
      if (exp_q.size() != 0)
        cyc();
    cyc();
    check1("fifo_filled", 1'b1, full);
    check("queue_left", 16'h0, 16'(exp_q.size()));
    check1("ready_again", 1'b1, conv_ready);
    $display("t_burst done");
  endtask

  // A hang is cut short well after the expected run length.
  initial
  begin
    #50000;
    num_errors++;
    $display("Watchdog expired");
    wrap_up();
  end

  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    cyc();
    check1("ready_rst", 1'b1, conv_ready);
    check1("dv_rst", 1'b0, dv);
    t_single();
    t_disabled();
    t_tag();
    t_fabric();
    t_burst();
    wrap_up();
  end
endmodule
